// File: include/gain_pkg.sv
package gain_pkg;
	localparam int unsigned CLK_HZ         = 250_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned TICK_DIV       = 8;
	localparam int unsigned PULSES_PER_REV = 2;
	// speed in rpm = RPM_NUM / captured period in ticks
	localparam logic [31:0] RPM_NUM = 32'(64'd60 * CLK_HZ / (TICK_DIV * PULSES_PER_REV));
	localparam logic [2:0]  TICK_LAST = 3'(TICK_DIV - 1);

	localparam int unsigned N_BP     = 28;
	localparam logic [4:0]  TOP_IDX  = 5'h1B;
	localparam logic [15:0] RPM_MIN  = 16'h07D0;
	localparam logic [15:0] RPM_MAX  = 16'h222E;
	localparam logic [15:0] RPM_STEP = 16'h00FA;
	// 65536/250 rounded, stands in for a divide by the breakpoint step
	localparam logic [16:0] STEP_RECIP = 17'h00106;

	localparam logic [7:0]  FACT_MIN = 8'h4B;
	localparam logic [7:0]  FACT_MAX = 8'h7D;
	localparam logic [7:0]  FACT_RST = 8'h64;
	localparam logic [23:0] PCT_DEN  = 24'h000064;
	localparam logic [9:0]  OUT_MAX  = 10'h3FF;
	localparam logic [9:0]  THR_LO_RST = 10'h0CD;
	localparam logic [9:0]  THR_HI_RST = 10'h333;

	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_RPM  = 12'h004;
	localparam logic [11:0] ADDR_OUT  = 12'h008;
	localparam logic [11:0] ADDR_TBL  = 12'h100;
	localparam logic [2:0]  HSIZE_WORD = 3'h2;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RPM  = 7'h02,
		ST_SEG  = 7'h04,
		ST_FAC  = 7'h08,
		ST_THR  = 7'h10,
		ST_WGT  = 7'h20,
		ST_OUT  = 7'h40
	} gain_state_t;
endpackage : gain_pkg

// File: design/airflow_recalibration_gain.sv
// Functional notes
// RULE1: every stored factor stays within 75 to 125 percent; other writes are dropped.
// RULE2: a table of 28 speed breakpoints, 2000 to 8750 rpm at 250 rpm steps, each with two factors.
// RULE3: software sets a low and a high throttle threshold that classify the throttle.
// RULE4: in range and throttle below the low threshold, the low-throttle factor is used.
// RULE5: between the thresholds, the two factors are interpolated linearly on throttle.
// RULE6: in range, factors are interpolated linearly between the two bracketing breakpoints.
// RULE7: below 2000 rpm the airflow sample is passed through unchanged.
// RULE8: above 8750 rpm the factors of the 8750 rpm breakpoint are used.
// RULE9: the airflow sample arrives as a 10-bit converted code.
// RULE10: speed comes from a period counter ticking every 8 clocks, captured and cleared per ignition edge.
// RULE11: throttle above the high threshold uses the high-throttle factor.
// RULE12: the sample is multiplied by the final factor and saturated to the output code range.
module airflow_recalibration_gain (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ign_pulse,
	input  wire logic        sample_valid,
	input  wire logic [9:0]  airflow_sample,
	input  wire logic [9:0]  throttle_sample,
	output logic             sample_ready,
	output logic             gain_valid,
	output logic      [9:0]  gain_code
);
	import gain_pkg::*;

	function automatic logic fact_ok(input logic [7:0] f);
		return (f >= FACT_MIN) && (f <= FACT_MAX);
	endfunction : fact_ok

	// a + (b - a) * wt / 2^sh, signed so a falling curve works too
	function automatic logic [7:0] lerp(input logic [7:0] a, input logic [7:0] b,
			input logic [16:0] wt, input int sh);
		logic signed [31:0] d;
		d = (signed'({24'h0, b}) - signed'({24'h0, a})) * signed'({15'h0, wt});
		return 8'(signed'({24'h0, a}) + (d >>> sh));
	endfunction : lerp

	// ignition period measurement
	logic        ign_d_r;
	logic [2:0]  presc_r, presc_nxt;
	logic [23:0] tick_r, tick_nxt;
	logic [23:0] period_r, period_nxt;
	logic        ign_rise;

	assign ign_rise = ign_pulse & ~ign_d_r;

	always_comb begin
		presc_nxt  = presc_r + 3'h1;
		tick_nxt   = tick_r;
		period_nxt = period_r;
		// saturate rather than wrap so a stalled engine reads as very slow
		if (presc_r == TICK_LAST && tick_r != 24'hFFFFFF) begin
			tick_nxt = tick_r + 24'h000001; // see RULE10
		end
		if (ign_rise) begin
			period_nxt = tick_r; // see RULE10
			tick_nxt   = 24'h000000;
			presc_nxt  = 3'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ign_d_r  <= 1'b0;
			presc_r  <= 3'h0;
			tick_r   <= 24'h000000;
			period_r <= 24'h000000;
		end else begin
			ign_d_r  <= ign_pulse;
			presc_r  <= presc_nxt;
			tick_r   <= tick_nxt;
			period_r <= period_nxt;
		end
	end

	// bus slave, zero wait states
	logic        ap_wr_r, ap_wr_nxt;
	logic [11:0] ap_addr_r, ap_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [9:0]  thr_lo_r, thr_lo_nxt, thr_hi_r, thr_hi_nxt;
	logic [7:0]  tlo_r [N_BP];
	logic [7:0]  thi_r [N_BP];
	logic [7:0]  tlo_nxt [N_BP];
	logic [7:0]  thi_nxt [N_BP];
	logic [15:0] rpm_r;
	logic [9:0]  gain_code_r;
	logic        ap_take, tbl_wr;

	assign ap_take = hsel & htrans[1] & hready;
	assign tbl_wr  = ap_wr_r && ap_addr_r[11:7] == ADDR_TBL[11:7]
		&& fact_ok(hwdata[7:0]) && fact_ok(hwdata[15:8]); // see RULE1

	always_comb begin
		ap_wr_nxt   = ap_take & hwrite & (hsize == HSIZE_WORD);
		ap_addr_nxt = ap_take ? haddr[11:0] : ap_addr_r;
		hrdata_nxt  = hrdata_r;
		thr_lo_nxt  = thr_lo_r;
		thr_hi_nxt  = thr_hi_r;
		if (ap_wr_r && ap_addr_r == ADDR_CTRL) begin
			thr_lo_nxt = hwdata[9:0]; // see RULE3
			thr_hi_nxt = hwdata[25:16];
		end
		if (ap_take && !hwrite) begin
			hrdata_nxt = 32'h00000000;
			if (haddr[11:0] == ADDR_CTRL) begin
				hrdata_nxt = {6'h00, thr_hi_r, 6'h00, thr_lo_r};
			end else if (haddr[11:0] == ADDR_RPM) begin
				hrdata_nxt = {16'h0000, rpm_r};
			end else if (haddr[11:0] == ADDR_OUT) begin
				hrdata_nxt = {22'h000000, gain_code_r};
			end else if (haddr[11:7] == ADDR_TBL[11:7] && haddr[6:2] <= TOP_IDX) begin
				hrdata_nxt = {16'h0000, thi_r[haddr[6:2]], tlo_r[haddr[6:2]]};
			end
		end
	end

	for (genvar i = 0; i < N_BP; i++) begin : g_bp
		// one word per breakpoint: low factor in [7:0], high factor in [15:8]
		assign tlo_nxt[i] = (tbl_wr && ap_addr_r[6:2] == 5'(i)) ? hwdata[7:0] : tlo_r[i];
		assign thi_nxt[i] = (tbl_wr && ap_addr_r[6:2] == 5'(i)) ? hwdata[15:8] : thi_r[i];
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				tlo_r[i] <= FACT_RST;
				thi_r[i] <= FACT_RST;
			end else begin
				tlo_r[i] <= tlo_nxt[i]; // see RULE2
				thi_r[i] <= thi_nxt[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r   <= 1'b0;
			ap_addr_r <= 12'h000;
			hrdata_r  <= 32'h00000000;
			thr_lo_r  <= THR_LO_RST;
			thr_hi_r  <= THR_HI_RST;
		end else begin
			ap_wr_r   <= ap_wr_nxt;
			ap_addr_r <= ap_addr_nxt;
			hrdata_r  <= hrdata_nxt;
			thr_lo_r  <= thr_lo_nxt;
			thr_hi_r  <= thr_hi_nxt;
		end
	end

	// both answers are constant, kept in flops so every output is registered
	logic hready_out_r;
	logic hresp_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hready_out_r <= 1'b1;
			hresp_r      <= 1'b0;
		end else begin
			hready_out_r <= 1'b1;
			hresp_r      <= 1'b0;
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = hready_out_r;
	assign hresp     = hresp_r;

	// gain pipeline; one shared serial divider keeps the area small at the
	// cost of about 100 cycles per sample, far below the sensor rate
	gain_state_t state_r, state_nxt;
	logic [9:0]  air_r, air_nxt, thr_r, thr_nxt;
	logic [15:0] rpm_nxt, srem_r, srem_nxt;
	logic [4:0]  idx_r, idx_nxt, idx_up;
	logic [7:0]  flo_r, flo_nxt, fhi_r, fhi_nxt, factor_r, factor_nxt;
	logic [31:0] dq_r, dq_nxt, dq_s;
	logic [23:0] drem_r, drem_nxt, dden_r, dden_nxt, drem_s;
	logic [4:0]  dcnt_r, dcnt_nxt;
	logic [24:0] dt, dsub;
	logic        dge, ddone;
	logic [15:0] rpm_q;
	logic [9:0]  out_q, gain_code_nxt;
	logic        gain_valid_r, gain_valid_nxt, ready_r, ready_nxt;
	logic [7:0]  fac_w;

	assign dt     = {drem_r, dq_r[31]};
	assign dsub   = dt - {1'b0, dden_r};
	assign dge    = dt >= {1'b0, dden_r};
	assign drem_s = dge ? dsub[23:0] : dt[23:0];
	assign dq_s   = {dq_r[30:0], dge};
	assign ddone  = dcnt_r == 5'h1F;
	assign rpm_q  = (dq_s[31:16] != 16'h0000) ? 16'hFFFF : dq_s[15:0];
	assign out_q  = (dq_s > {22'h000000, OUT_MAX}) ? OUT_MAX : dq_s[9:0]; // see RULE12
	assign idx_up = (idx_r == TOP_IDX) ? idx_r : idx_r + 5'h01;
	assign fac_w  = lerp(flo_r, fhi_r, {8'h00, dq_s[8:0]}, 8); // see RULE5

	always_comb begin
		state_nxt      = state_r;
		air_nxt        = air_r;
		thr_nxt        = thr_r;
		rpm_nxt        = rpm_r;
		srem_nxt       = srem_r;
		idx_nxt        = idx_r;
		flo_nxt        = flo_r;
		fhi_nxt        = fhi_r;
		factor_nxt     = factor_r;
		dq_nxt         = dq_s;
		drem_nxt       = drem_s;
		dden_nxt       = dden_r;
		dcnt_nxt       = dcnt_r + 5'h01;
		gain_valid_nxt = 1'b0;
		gain_code_nxt  = gain_code_r;
		case (state_r)
			ST_IDLE: begin
				if (sample_valid && ready_r) begin
					air_nxt = airflow_sample; // see RULE9
					thr_nxt = throttle_sample;
					if (period_r == 24'h000000) begin
						// no ignition seen yet: treat as a stopped engine
						rpm_nxt        = 16'h0000;
						gain_valid_nxt = 1'b1;
						gain_code_nxt  = airflow_sample;
					end else begin
						dq_nxt    = RPM_NUM;
						drem_nxt  = 24'h000000;
						dden_nxt  = period_r;
						dcnt_nxt  = 5'h00;
						state_nxt = ST_RPM;
					end
				end
			end
			ST_RPM: begin
				if (ddone) begin
					rpm_nxt = rpm_q;
					if (rpm_q < RPM_MIN) begin
						gain_valid_nxt = 1'b1; // see RULE7
						gain_code_nxt  = air_r;
						state_nxt      = ST_IDLE;
					end else if (rpm_q >= RPM_MAX) begin
						idx_nxt   = TOP_IDX; // see RULE8
						srem_nxt  = 16'h0000;
						state_nxt = ST_FAC;
					end else begin
						idx_nxt   = 5'h00;
						srem_nxt  = rpm_q - RPM_MIN;
						state_nxt = ST_SEG;
					end
				end
			end
			ST_SEG: begin
				if (srem_r >= RPM_STEP) begin
					srem_nxt = srem_r - RPM_STEP; // see RULE6
					idx_nxt  = idx_r + 5'h01;
				end else begin
					state_nxt = ST_FAC;
				end
			end
			ST_FAC: begin
				flo_nxt   = lerp(tlo_r[idx_r], tlo_r[idx_up], 17'(srem_r * STEP_RECIP), 16); // see RULE6
				fhi_nxt   = lerp(thi_r[idx_r], thi_r[idx_up], 17'(srem_r * STEP_RECIP), 16);
				state_nxt = ST_THR;
			end
			ST_THR: begin
				dq_nxt   = {22'h000000, air_r} * {24'h000000, flo_r};
				drem_nxt = 24'h000000;
				dden_nxt = PCT_DEN;
				dcnt_nxt = 5'h00;
				if (thr_r <= thr_lo_r) begin
					factor_nxt = flo_r; // see RULE4
					state_nxt  = ST_OUT;
				end else if (thr_r >= thr_hi_r) begin
					factor_nxt = fhi_r; // see RULE11
					dq_nxt     = {22'h000000, air_r} * {24'h000000, fhi_r};
					state_nxt  = ST_OUT;
				end else begin
					dq_nxt    = {14'h0000, thr_r - thr_lo_r, 8'h00}; // see RULE5
					dden_nxt  = {14'h0000, thr_hi_r - thr_lo_r};
					state_nxt = ST_WGT;
				end
			end
			ST_WGT: begin
				if (ddone) begin
					factor_nxt = fac_w;
					dq_nxt     = {22'h000000, air_r} * {24'h000000, fac_w};
					drem_nxt   = 24'h000000;
					dden_nxt   = PCT_DEN;
					dcnt_nxt   = 5'h00;
					state_nxt  = ST_OUT;
				end
			end
			ST_OUT: begin
				if (ddone) begin
					gain_valid_nxt = 1'b1;
					gain_code_nxt  = out_q; // see RULE12
					state_nxt      = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		ready_nxt = (state_nxt == ST_IDLE) && !(state_r == ST_IDLE && sample_valid && ready_r);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r      <= ST_IDLE;
			air_r        <= 10'h000;
			thr_r        <= 10'h000;
			rpm_r        <= 16'h0000;
			srem_r       <= 16'h0000;
			idx_r        <= 5'h00;
			flo_r        <= FACT_RST;
			fhi_r        <= FACT_RST;
			factor_r     <= FACT_RST;
			dq_r         <= 32'h00000000;
			drem_r       <= 24'h000000;
			dden_r       <= 24'h000001;
			dcnt_r       <= 5'h00;
			gain_valid_r <= 1'b0;
			gain_code_r  <= 10'h000;
			ready_r      <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			air_r        <= air_nxt;
			thr_r        <= thr_nxt;
			rpm_r        <= rpm_nxt;
			srem_r       <= srem_nxt;
			idx_r        <= idx_nxt;
			flo_r        <= flo_nxt;
			fhi_r        <= fhi_nxt;
			factor_r     <= factor_nxt;
			dq_r         <= dq_nxt;
			drem_r       <= drem_nxt;
			dden_r       <= dden_nxt;
			dcnt_r       <= dcnt_nxt;
			gain_valid_r <= gain_valid_nxt;
			gain_code_r  <= gain_code_nxt;
			ready_r      <= ready_nxt;
		end
	end

	assign sample_ready = ready_r;
	assign gain_valid   = gain_valid_r;
	assign gain_code    = gain_code_r;

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [17:0] exp_prod;
	// full-width product: a 10-bit self-sized product would wrap
	assign exp_prod = ({8'h00, air_r} * {10'h000, factor_r}) / 18'h00064;

	AST_FACT_RANGE: assert property (state_r == ST_THR |-> flo_r >= FACT_MIN && flo_r <= FACT_MAX
		&& fhi_r >= FACT_MIN && fhi_r <= FACT_MAX) else $error("factor out of range"); // see RULE1
	AST_PERIOD_CAP: assert property (ign_rise |=> period_r == $past(tick_r) && tick_r == 24'h000000)
		else $error("period not captured"); // see RULE10
	AST_PASS_LOW: assert property (state_r == ST_RPM && ddone && rpm_q < RPM_MIN
		|=> gain_valid_r && gain_code_r == $past(air_r) && state_r == ST_IDLE)
		else $error("low speed not passed through"); // see RULE7
	AST_TOP_HOLD: assert property (state_r == ST_RPM && ddone && rpm_q >= RPM_MAX
		|=> idx_r == TOP_IDX && srem_r == 16'h0000 && state_r == ST_FAC)
		else $error("top breakpoint not held"); // see RULE8
	AST_BRACKET: assert property (state_r == ST_FAC |-> srem_r < RPM_STEP && idx_r <= TOP_IDX)
		else $error("speed not bracketed"); // see RULE6
	AST_THR_LOW: assert property (state_r == ST_THR && thr_r <= thr_lo_r
		|=> factor_r == $past(flo_r) && state_r == ST_OUT) else $error("low factor not used"); // see RULE4
	AST_THR_HIGH: assert property (state_r == ST_THR && thr_r > thr_lo_r && thr_r >= thr_hi_r
		|=> factor_r == $past(fhi_r)) else $error("high factor not used"); // see RULE11
	AST_THR_MID: assert property (state_r == ST_THR && thr_r > thr_lo_r && thr_r < thr_hi_r
		|=> state_r == ST_WGT ##[1:40] state_r == ST_OUT) else $error("no interpolation"); // see RULE5
	AST_SCALE: assert property (state_r == ST_OUT && ddone |=> gain_valid_r
		&& gain_code_r == (($past(exp_prod) > 18'h003FF) ? OUT_MAX : $past(exp_prod[9:0])))
		else $error("scaled output wrong"); // see RULE12
	AST_THR_CFG: assert property (ap_wr_r && ap_addr_r == ADDR_CTRL
		|=> thr_lo_r == $past(hwdata[9:0]) && thr_hi_r == $past(hwdata[25:16]))
		else $error("threshold write lost"); // see RULE3
endmodule : airflow_recalibration_gain

// File: test/sensor_link_model.sv
module sensor_link_model (
	input  wire logic       hclk,
	output logic            ign_pulse,
	output logic            sample_valid,
	output logic [9:0]      airflow_sample,
	output logic [9:0]      throttle_sample,
	input  wire logic       sample_ready,
	input  wire logic       gain_valid,
	input  wire logic [9:0] gain_code
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		ign_pulse = 1'b0;
		sample_valid = 1'b0;
		airflow_sample = 10'h2AA;
		throttle_sample = 10'h155;
	end

	// one ignition pulse, then quiet for the rest of the gap
	task automatic ignite(input int gap);
		@(posedge hclk);
		ign_pulse <= 1'b1;
		repeat (4) @(posedge hclk);
		ign_pulse <= 1'b0;
		repeat (gap - 4) @(posedge hclk);
	endtask : ignite

	task automatic convert(input logic [9:0] af, input logic [9:0] thr,
			output logic [9:0] code, output bit ok);
		int k;
		@(posedge hclk);
		sample_valid <= 1'b1;
		airflow_sample <= af;
		throttle_sample <= thr;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (sample_ready !== 1'b1 && k < 100);
		sample_valid <= 1'b0;
		// released lines show a changed value so a stale capture cannot pass
		airflow_sample <= ~af;
		throttle_sample <= ~thr;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (gain_valid !== 1'b1 && k < 300);
		code = gain_code;
		ok = (gain_valid === 1'b1);
	endtask : convert
endmodule : sensor_link_model

// File: test/airflow_recalibration_gain_tb.sv
module airflow_recalibration_gain_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gain_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ign_pulse;
	logic        sample_valid;
	logic [9:0]  airflow_sample;
	logic [9:0]  throttle_sample;
	logic        sample_ready;
	logic        gain_valid;
	logic [9:0]  gain_code;
	int          num_errors;
	int          n_checks;

	airflow_recalibration_gain u_airflow_recalibration_gain (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ign_pulse(ign_pulse), .sample_valid(sample_valid),
		.airflow_sample(airflow_sample), .throttle_sample(throttle_sample),
		.sample_ready(sample_ready), .gain_valid(gain_valid), .gain_code(gain_code)
	);

	sensor_link_model u_sensor_link_model (
		.hclk(hclk), .ign_pulse(ign_pulse), .sample_valid(sample_valid),
		.airflow_sample(airflow_sample), .throttle_sample(throttle_sample),
		.sample_ready(sample_ready), .gain_valid(gain_valid), .gain_code(gain_code)
	);

	initial hclk = 1'b0;
	always #(CLK_PERIOD_NS / 2) hclk = ~hclk;

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			$display("MISMATCH t=%0t bus hang", $time);
			end_of_test();
		end
	endtask : wait_ready

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		check({31'h0, hresp}, 32'h0, "okay response");
	endtask : ahb

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		check(r, exp, "register read");
	endtask : rd_chk

	// one sample through the partner model; a lost answer ends the run
	task automatic conv_chk(input logic [9:0] af, input logic [9:0] thr, input logic [9:0] exp);
		logic [9:0] c;
		bit         k;
		u_sensor_link_model.convert(af, thr, c, k);
		check({k, 21'h0, c}, {1'b1, 21'h0, exp}, "gain");
		if (!k) begin
			end_of_test();
		end
	endtask : conv_chk

	// reference gain: throttle axis only, used above the table top
	function automatic logic [9:0] ref_gain(input int af, input int thr);
		int f;
		int w;
		int o;
		if (thr <= 'h100) f = 80;
		else if (thr >= 'h300) f = 120;
		else begin
			w = ((thr - 'h100) << 8) / 'h200;
			f = 80 + ((40 * w) >>> 8);
		end
		o = af * f / 100;
		return (o > 1023) ? 10'h3FF : 10'(o);
	endfunction : ref_gain

	logic [31:0] dummy;
	int          af_t [6] = '{500, 500, 600, 500, 500, 1000};
	int          thr_t [6] = '{'h080, 'h100, 'h200, 'h2FF, 'h300, 'h3FF};
	logic [31:0] bad_t [2] = '{32'h0000_7E50, 32'h0000_784A};

	initial begin
		num_errors = 0;
		n_checks = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(32'(ADDR_CTRL), 32'h0333_00CD);
		rd_chk(32'(ADDR_RPM), 32'h0);
		rd_chk(32'h0000_00FC, 32'h0);
		ahb(1'b1, 32'(ADDR_CTRL), 32'h0300_0100, dummy);
		rd_chk(32'(ADDR_CTRL), 32'h0300_0100);
		ahb(1'b1, 32'h0000_0100, 32'h0000_7D4B, dummy);
		rd_chk(32'h0000_0100, 32'h0000_7D4B);
		ahb(1'b1, 32'h0000_016C, 32'h0000_7850, dummy);
		foreach (bad_t[i]) begin
			// out-of-range factors must leave the stored pair untouched
			ahb(1'b1, 32'h0000_016C, bad_t[i], dummy);
			rd_chk(32'h0000_016C, 32'h0000_7850);
		end
		rd_chk(32'h0000_0170, 32'h0);
		// no ignition yet: samples pass through untouched
		conv_chk(10'h3FF, 10'h3FF, 10'h3FF);
		conv_chk(10'h155, 10'h000, 10'h155);
		rd_chk(32'(ADDR_OUT), 32'h0000_0155);
		// short period puts speed far above the table top
		u_sensor_link_model.ignite(4000);
		u_sensor_link_model.ignite(4000);
		foreach (af_t[i]) begin
			conv_chk(10'(af_t[i]), 10'(thr_t[i]), ref_gain(af_t[i], thr_t[i]));
		end
		rd_chk(32'(ADDR_OUT), 32'h0000_03FF);
		// 500 ticks per ignition gap: speed saturates at the top code
		rd_chk(32'(ADDR_RPM), 32'h0000_FFFF);
		// mid-run reset brings thresholds, table and speed back to defaults
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(32'(ADDR_CTRL), 32'h0333_00CD);
		rd_chk(32'h0000_016C, 32'h0000_6464);
		conv_chk(10'h2AA, 10'h3FF, 10'h2AA);
		rd_chk(32'(ADDR_RPM), 32'h0);
		end_of_test();
	end
endmodule : airflow_recalibration_gain_tb
